// *** hdl/hsp_protect.sv ***
`timescale 1ns/10ps
// Contract
// (R01) one 250 uA diode step each millisecond
// (R02) temperature command 8Dh returns latest reading
// (R03) above warning limit, alert unless masked
// (R04) above shutdown limit, gate off as fault
// (R05) host reprograms both limits, comparisons follow
// (R06) host restarts with 0h then 80h
// (R07) sense above 4 mV, gate low: flag
// (R08) undervoltage or overvoltage forces gate low
// (R09) enable toggle clears retry lockout
// (R10) pin activity keeps address and settings
// (R11) 80h enables output, 0h disables it
// (R12) latch ternary address after supply power-on
// (R13) reference low resets, delays address capture
// (R14) current limit from pin or setup
// (R15) breaker ratio 1.94 or 3.87 selectable
// (R16) fault timer runs while limiting
// (R17) retry count 0,1,2,4,8,16 or unlimited
// (R18) lockout flag high while latched off
// (R19) flags and alert hold until cleared
// (R20) compare each reading in its interval
module hsp_protect import hsp_pkg::*; #(
    parameter logic [6:0] ADDR_BASE = 7'h40,
    parameter int MEAS_PERIOD = MEAS_CYCLES,
    parameter int MEAS_STEP = STEP_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // smbus
    input wire logic smb_scl,
    input wire logic smb_sda_in,
    output logic smb_sda_out,
    output logic smb_sda_oe_n,
    output logic alert_line_out,
    output logic alert_line_out_oe_n,
    // supervision pins
    input wire logic enable_undervoltage_input,
    input wire logic overvoltage_input,
    input wire logic vdd_por_ok,
    input wire logic reference_low,
    input wire logic reference_ready,
    input wire logic [1:0] address_select_0,
    input wire logic [1:0] address_select_1,
    input wire logic [1:0] address_select_2,
    input wire logic limit_range_select,
    input wire logic breaker_range_select,
    // analog status
    input wire logic sense_above_4mv,
    input wire logic current_limit_active,
    input wire logic timer_expired,
    input wire logic restart_ramp_done,
    // temperature converter, same clock
    input wire logic [15:0] temp_code_in,
    // drives
    output logic diode_step_on,
    output logic gate_drive_on,
    output logic fault_timer_run,
    output logic limit_50mv_sel,
    output logic breaker_ratio_hi
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        hsp_bus_t mode;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [1:0] byte_idx;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic sda_drv;
        logic ack_ok;
        logic scl_prev;
        logic sda_prev;
        logic [7:0] operation;
        logic [15:0] ot_fault_lim;
        logic [15:0] ot_warn_lim;
        logic [15:0] alert_mask;
        logic [7:0] setup;
        logic [15:0] temp;
        logic addr_valid;
        logic [6:0] addr;
        logic [5:0] flags;
        logic ot_shut;
        logic lockout;
        logic retry_wait;
        logic [4:0] retries_left;
        logic timer_prev;
        logic ramp_prev;
        logic gate;
        logic ftimer;
        logic alert;
        logic cl50;
        logic cbhi;
    } hsp_state_t;

    hsp_state_t s;
    hsp_state_t n;
    hsp_state_t init;

    logic [18:0] raw;
    logic [18:0] syn;
    logic scl_s, sda_s, en_uv_s, ov_s, por_s, ref_low_s, ref_rdy_s;
    logic [1:0] a0_s, a1_s, a2_s;
    logic lim_pin_s, brk_pin_s, sense_s, climit_s, texp_s, ramp_s;
    logic meas_sample;
    logic rise, fall, start, stop;
    logic [15:0] rd;
    logic [7:0] rd_byte;
    logic [5:0] flag_set;
    logic flag_clr;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] trit(input logic [1:0] p);
        // ground, open, supply
        case (p)
            2'b01: trit = 5'd1;
            2'b10: trit = 5'd2;
            default: trit = 5'd0;
        endcase
    endfunction

    function automatic logic [4:0] retry_load(input logic [2:0] code);
        case (code)
            3'd1: retry_load = 5'd1;
            3'd2: retry_load = 5'd2;
            3'd3: retry_load = 5'd4;
            3'd4: retry_load = 5'd8;
            3'd5: retry_load = 5'd16;
            default: retry_load = 5'd0;
        endcase
    endfunction

    function automatic logic [15:0] rd_word(input hsp_state_t st);
        case (st.cmd)
            CMD_OPERATION: rd_word = {8'h00, st.operation};
            CMD_OT_FAULT: rd_word = st.ot_fault_lim;
            CMD_OT_WARN: rd_word = st.ot_warn_lim;
            CMD_VSTATUS: rd_word = {8'h00, st.flags[DG_SHORT], 7'h00};
            CMD_TEMP: rd_word = st.temp; // R02
            CMD_ALERT_MASK: rd_word = st.alert_mask;
            CMD_SETUP: rd_word = {8'h00, st.setup};
            CMD_DIAG: rd_word = {10'h000, st.flags[5:2], st.lockout, st.flags[DG_SHORT]}; // R18
            default: rd_word = {RD_IDLE, RD_IDLE};
        endcase
    endfunction

    // ****************************************
    // pin synchronisers and measurement timer
    // ****************************************
    assign raw = {smb_scl, smb_sda_in, enable_undervoltage_input, overvoltage_input, vdd_por_ok,
                  reference_low, reference_ready, address_select_0, address_select_1,
                  address_select_2, limit_range_select, breaker_range_select, sense_above_4mv,
                  current_limit_active, timer_expired, restart_ramp_done};
    assign {scl_s, sda_s, en_uv_s, ov_s, por_s, ref_low_s, ref_rdy_s, a0_s, a1_s, a2_s,
            lim_pin_s, brk_pin_s, sense_s, climit_s, texp_s, ramp_s} = syn;

    hsp_sync #(.W(19)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(raw),
        .sync_out(syn)
    );

    hsp_meas_timer #(.PERIOD(MEAS_PERIOD), .STEP(MEAS_STEP)) u_meas (
        .ref_clk(ref_clk),
        .rst(rst),
        .step_on(diode_step_on), // R01
        .sample(meas_sample)
    );

    assign rise = scl_s & ~s.scl_prev;
    assign fall = ~scl_s & s.scl_prev;
    assign start = scl_s & s.scl_prev & s.sda_prev & ~sda_s;
    assign stop = scl_s & s.scl_prev & ~s.sda_prev & sda_s;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        init = '0;
        init.operation = OP_RST;
        init.ot_fault_lim = OT_FAULT_RST;
        init.ot_warn_lim = OT_WARN_RST;
        init.alert_mask = MASK_RST;
        init.setup = SETUP_RST;
        init.scl_prev = 1'b1;
        init.sda_prev = 1'b1;
        init.retries_left = retry_load(SETUP_RST[SU_RETRY +: 3]);
        n = s;
        rd = rd_word(s);
        rd_byte = (s.byte_idx == 2'd0) ? rd[7:0] : (s.byte_idx == 2'd1) ? rd[15:8] : RD_IDLE;
        flag_set = '0;
        flag_clr = 1'b0;
        n.scl_prev = scl_s;
        n.sda_prev = sda_s;
        n.timer_prev = texp_s;
        n.ramp_prev = ramp_s;

        // smbus slave
        if (start)
        begin
            n.mode = BUS_ADDR;
            n.bitcnt = '0;
            n.byte_idx = '0;
            n.sda_drv = 1'b0;
        end
        else if (stop)
        begin
            n.mode = BUS_IDLE;
            n.sda_drv = 1'b0;
        end
        else if (s.mode != BUS_IDLE && rise)
        begin
            if (s.bitcnt < 4'd8)
                n.shreg = {s.shreg[6:0], sda_s};
            if (s.bitcnt == 4'd8)
                n.ack_ok = ~sda_s;
            n.bitcnt = s.bitcnt + 4'd1;
        end
        else if (s.mode != BUS_IDLE && fall)
        begin
            if (s.bitcnt == 4'd8)
            begin
                n.sda_drv = 1'b0;
                case (s.mode)
                    BUS_ADDR:
                    begin
                        if (s.addr_valid && s.shreg[7:1] == s.addr)
                        begin
                            n.sda_drv = 1'b1;
                            n.mode = s.shreg[0] ? BUS_READ : BUS_WRITE;
                        end
                        else
                            n.mode = BUS_IDLE;
                    end
                    BUS_WRITE:
                    begin
                        n.sda_drv = 1'b1;
                        if (s.byte_idx != 2'd3)
                            n.byte_idx = s.byte_idx + 2'd1;
                        if (s.byte_idx == 2'd0)
                        begin
                            n.cmd = s.shreg;
                            flag_clr = (s.shreg == CMD_CLEAR_FLAGS); // R19
                        end
                        else if (s.byte_idx == 2'd1)
                        begin
                            n.lo = s.shreg;
                            if (s.cmd == CMD_OPERATION)
                            begin
                                n.operation = s.shreg; // R11
                                n.retries_left = retry_load(s.setup[SU_RETRY +: 3]);
                                if (s.shreg == OP_OFF)
                                    n.ot_shut = 1'b0; // R06
                            end
                            if (s.cmd == CMD_SETUP)
                            begin
                                n.setup = s.shreg;
                                n.retries_left = retry_load(s.shreg[SU_RETRY +: 3]); // R17
                            end
                        end
                        else if (s.byte_idx == 2'd2)
                        begin
                            case (s.cmd)
                                CMD_OT_FAULT: n.ot_fault_lim = {s.shreg, s.lo}; // R05
                                CMD_OT_WARN: n.ot_warn_lim = {s.shreg, s.lo}; // R05
                                CMD_ALERT_MASK: n.alert_mask = {s.shreg, s.lo};
                                default: ;
                            endcase
                        end
                    end
                    default: ;
                endcase
            end
            else if (s.bitcnt == 4'd9)
            begin
                n.bitcnt = '0;
                n.sda_drv = 1'b0;
                if (s.mode == BUS_READ)
                begin
                    // a master nack ends the read; wait for stop
                    if (s.ack_ok)
                    begin
                        n.tx = rd_byte;
                        n.sda_drv = ~rd_byte[7];
                        if (s.byte_idx != 2'd3)
                            n.byte_idx = s.byte_idx + 2'd1;
                    end
                    else
                        n.mode = BUS_IDLE;
                end
            end
            else if (s.mode == BUS_READ)
                n.sda_drv = ~s.tx[3'(4'd7 - s.bitcnt)];
        end

        // address capture, once per power-on or reference release
        if (!s.addr_valid && por_s && ref_rdy_s) // R10
        begin
            n.addr_valid = 1'b1; // R12 R13
            n.addr = ADDR_BASE + 7'(trit(a2_s) * 5'd9 + trit(a1_s) * 5'd3 + trit(a0_s));
        end

        // temperature, compared in the interval it completes
        if (meas_sample)
        begin
            n.temp = temp_code_in; // R20
            if (temp_code_in > s.ot_warn_lim)
                flag_set[DG_OTW] = 1'b1; // R03
            if (temp_code_in > s.ot_fault_lim)
            begin
                flag_set[DG_OTF] = 1'b1;
                n.ot_shut = 1'b1; // R04
            end
        end

        // damaged pass switch detect
        if (!s.gate && sense_s)
            flag_set[DG_SHORT] = 1'b1; // R07
        flag_set[DG_UV] = ~en_uv_s & s.operation[7];
        flag_set[DG_OV] = ov_s;

        // fault timeout and retries
        if (texp_s && !s.timer_prev && s.gate)
        begin
            if (s.setup[SU_RETRY +: 3] >= 3'd6)
                n.retry_wait = 1'b1; // R17
            else if (s.retries_left != 5'd0)
            begin
                n.retry_wait = 1'b1;
                n.retries_left = s.retries_left - 5'd1;
            end
            else
                n.lockout = 1'b1; // R18
        end
        if (ramp_s && !s.ramp_prev && s.retry_wait)
            n.retry_wait = 1'b0;
        // toggling enable low releases a lockout; rise restarts
        if (!en_uv_s)
        begin
            n.lockout = 1'b0; // R09
            n.retry_wait = 1'b0;
            n.retries_left = retry_load(s.setup[SU_RETRY +: 3]);
        end

        // set wins over clear
        n.flags = (s.flags & ~{6{flag_clr}}) | flag_set; // R19

        // outputs
        n.gate = s.operation[7] & en_uv_s & ~ov_s & ~s.ot_shut & ~s.lockout & ~s.retry_wait; // R08 R11
        n.ftimer = climit_s & s.gate; // R16
        n.alert = |({s.flags[5:2], s.lockout, s.flags[DG_SHORT]} & ~s.alert_mask[5:0]); // R03 R07
        n.cl50 = s.setup[SU_LIM_SRC] ? s.setup[SU_LIM_50] : ~lim_pin_s; // R14
        n.cbhi = s.setup[SU_BRK_SRC] ? s.setup[SU_BRK_HI] : brk_pin_s; // R15

        // reference low reloads every register of this block with its reset value, address included; the measurement timer keeps running
        if (ref_low_s)
            n = init; // R13
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s <= init;
        else
            s <= n;
    end

    assign smb_sda_out = 1'b0;
    assign smb_sda_oe_n = ~s.sda_drv;
    assign alert_line_out = 1'b0;
    assign alert_line_out_oe_n = ~s.alert;
    assign gate_drive_on = s.gate;
    assign fault_timer_run = s.ftimer;
    assign limit_50mv_sel = s.cl50;
    assign breaker_ratio_hi = s.cbhi;

    // ****************************************
    // checks
    // ****************************************
    default clocking chk_clk @(posedge ref_clk); endclocking
    default disable iff (rst || ref_low_s);

    sequence s_shut_then_off;
        s.ot_shut ##1 !gate_drive_on;
    endsequence

    sequence s_no_new_step;
        !$rose(diode_step_on) [*8];
    endsequence

    a_gate_uv_off: assert property (!en_uv_s |=> !gate_drive_on) // R08
        else $error("gate on during undervoltage");
    a_gate_ov_off: assert property (ov_s |=> !gate_drive_on) // R08
        else $error("gate on during overvoltage");
    a_temp_capture: assert property (meas_sample |=> s.temp == $past(temp_code_in)) // R02
        else $error("temperature not captured");
    a_warn_flag: assert property (meas_sample && temp_code_in > s.ot_warn_lim |=> s.flags[DG_OTW]) // R03
        else $error("warning flag not set");
    a_shut_gate: assert property (meas_sample && temp_code_in > s.ot_fault_lim |=> s_shut_then_off) // R04
        else $error("overtemperature did not turn gate off");
    a_short_flag: assert property (!gate_drive_on && sense_s |=> s.flags[DG_SHORT]) // R07
        else $error("shorted switch flag missing");
    a_alert_short: assert property (s.flags[DG_SHORT] && !s.alert_mask[DG_SHORT] |=> !alert_line_out_oe_n) // R07
        else $error("alert not driven");
    a_flag_hold: assert property (s.flags[DG_OTW] && !flag_clr |=> s.flags[DG_OTW]) // R19
        else $error("flag dropped without clear");
    a_lock_gate: assert property (s.lockout |=> !gate_drive_on) // R18
        else $error("gate on while locked out");
    a_fault_timer: assert property (climit_s && gate_drive_on |=> fault_timer_run) // R16
        else $error("fault timer idle while limiting");
    a_step_period: assert property ($rose(diode_step_on) |=> s_no_new_step) // R01
        else $error("diode step too frequent");
    a_limit_pin: assert property (!s.setup[SU_LIM_SRC] |=> limit_50mv_sel == !$past(lim_pin_s)) // R14
        else $error("current limit range wrong");
endmodule // hsp_protect

// *** hdl/hsp_pkg.sv ***
package hsp_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_OPERATION = 8'h03;
    localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h04;
    localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
    localparam logic [7:0] CMD_OT_WARN = 8'h51;
    localparam logic [7:0] CMD_VSTATUS = 8'h80;
    localparam logic [7:0] CMD_TEMP = 8'h8D;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hD8;
    localparam logic [7:0] CMD_SETUP = 8'hD9;
    localparam logic [7:0] CMD_DIAG = 8'hE1;

    // ****************************************
    // values and reset values
    // ****************************************
    localparam logic [7:0] OP_ON = 8'h80;
    localparam logic [7:0] OP_OFF = 8'h00;
    localparam logic [7:0] OP_RST = 8'h80;
    localparam logic [15:0] OT_FAULT_RST = 16'h0096;
    localparam logic [15:0] OT_WARN_RST = 16'h007D;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] RD_IDLE = 8'hFF;

    // ****************************************
    // field positions
    // ****************************************
    localparam int DG_SHORT = 0;
    localparam int DG_LOCK = 1;
    localparam int DG_OTW = 2;
    localparam int DG_OTF = 3;
    localparam int DG_UV = 4;
    localparam int DG_OV = 5;
    localparam int VS_SHORT = 7;
    localparam int SU_LIM_SRC = 0;
    localparam int SU_LIM_50 = 1;
    localparam int SU_BRK_SRC = 2;
    localparam int SU_BRK_HI = 3;
    localparam int SU_RETRY = 4;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int MEAS_PERIOD_US = 1000;
    localparam int STEP_US = 100;
    localparam int MEAS_CYCLES = CLK_HZ / 1_000_000 * MEAS_PERIOD_US;
    localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ADDR = 2'b01,
        BUS_WRITE = 2'b10,
        BUS_READ = 2'b11
    } hsp_bus_t;

endpackage

// *** hdl/hsp_sync.sv ***
`timescale 1ns/10ps
module hsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hsp_sync_t;

    hsp_sync_t s;
    hsp_sync_t n;

    always_comb
    begin
        n.s1 = async_in;
        n.s2 = s.s1;
    end

    always_ff @(posedge ref_clk)
    begin
        // preload with the pin level so no false edge or flag follows reset
        if (rst)
            s <= {async_in, async_in};
        else
            s <= n;
    end

    assign sync_out = s.s2;
endmodule // hsp_sync

// *** hdl/hsp_meas_timer.sv ***
`timescale 1ns/10ps
module hsp_meas_timer import hsp_pkg::*; #(
    parameter int PERIOD = MEAS_CYCLES,
    parameter int STEP = STEP_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // measurement timing
    output logic step_on,
    output logic sample
);
    typedef struct packed {
        logic [15:0] cnt;
        logic step;
        logic smp;
    } hsp_meas_t;

    hsp_meas_t s;
    hsp_meas_t n;

    always_comb
    begin
        n = s;
        n.smp = 1'b0;
        if (s.cnt == 16'(PERIOD - 1))
        begin
            n.cnt = '0;
            n.step = 1'b1;
        end
        else
        begin
            n.cnt = s.cnt + 16'h0001;
        end
        // end of the current step: diode reading is settled
        if (s.cnt == 16'(STEP - 1))
        begin
            n.step = 1'b0;
            n.smp = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign step_on = s.step;
    assign sample = s.smp;
endmodule // hsp_meas_timer

// *** tb/hsp_host.sv ***
`timescale 1ns/10ps
module hsp_host (
    // clock
    input wire logic ref_clk,
    // smbus wires
    output logic smb_scl,
    output logic smb_sda_in,
    input wire logic smb_sda_oe_n
);
    // ****
    // bus master with open drain data
    // ****
    logic pull_q = 1'h0;
    logic [6:0] dev_addr = 7'h47;
    logic addr_nack = 1'h0;
    assign smb_sda_in = ~pull_q & smb_sda_oe_n;
    initial smb_scl = 1'h1;
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // sample late in the high phase, the device answers several clocks after a fall
    task automatic bit_io(input logic b, output logic r);
        w(1);
        pull_q = ~b;
        w(3);
        smb_scl = 1'h1;
        w(4);
        r = smb_sda_in;
        smb_scl = 1'h0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_in, ack);
    endtask
    task automatic cond(input logic p0, input logic p1);
        w(1);
        pull_q = p0;
        w(3);
        smb_scl = 1'h1;
        w(4);
        pull_q = p1;
        w(4);
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] d, input int n, input logic is_rd,
        output logic [15:0] q);
        logic [7:0] r;
        logic a;
        cond(1'h0, 1'h1);
        smb_scl = 1'h0;
        byte_io({dev_addr, 1'h0}, 1'h1, r, addr_nack);
        byte_io(cmd, 1'h1, r, a);
        if (is_rd)
        begin
            cond(1'h0, 1'h1);
            smb_scl = 1'h0;
            byte_io({dev_addr, 1'h1}, 1'h1, r, a);
        end
        for (int i = 0; i < n; i++)
        begin
            byte_io(is_rd ? 8'hFF : d[8*i +: 8], ~(is_rd && i == 0), r, a);
            q[8*i +: 8] = r;
        end
        cond(1'h1, 1'h0);
    endtask
endmodule // hsp_host

// *** tb/hotswap_protect_control_tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module hotswap_protect_control_tb import hsp_pkg::*; ;
    logic ref_clk = 1'h0, rst = 1'h1;
    logic scl, sda_in, sda_oe_n, alert_oe_n, step, gate, ftr, cl50, cbhi;
    logic en = 1'h1, ov = 1'h0, ref_low = 1'h0, lim_sel = 1'h1, brk_sel = 1'h0, por = 1'h1, rdy = 1'h1;
    logic sense = 1'h0, cla = 1'h0, texp = 1'h0, ramp = 1'h0;
    logic [1:0] as0 = 2'h1, as1 = 2'h2, as2 = 2'h0;
    logic [15:0] temp = 16'h0014, v;
    int failures = 0, check_count = 0, cyc = 0, step_hi = 0;
    initial forever #50 ref_clk = ~ref_clk;
    // short measurement period keeps the run brief: 40 cycles, step high for 8
    hsp_protect #(.MEAS_PERIOD(40), .MEAS_STEP(8)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .smb_scl(scl), .smb_sda_in(sda_in), .smb_sda_out(), .smb_sda_oe_n(sda_oe_n),
        .alert_line_out(), .alert_line_out_oe_n(alert_oe_n), .enable_undervoltage_input(en), .overvoltage_input(ov),
        .vdd_por_ok(por), .reference_low(ref_low), .reference_ready(rdy), .address_select_0(as0),
        .address_select_1(as1), .address_select_2(as2), .limit_range_select(lim_sel), .breaker_range_select(brk_sel),
        .sense_above_4mv(sense), .current_limit_active(cla), .timer_expired(texp), .restart_ramp_done(ramp),
        .temp_code_in(temp), .diode_step_on(step), .gate_drive_on(gate), .fault_timer_run(ftr),
        .limit_50mv_sel(cl50), .breaker_ratio_hi(cbhi));
    hsp_host host_u (.ref_clk(ref_clk), .smb_scl(scl), .smb_sda_in(sda_in), .smb_sda_oe_n(sda_oe_n));
    always @(posedge ref_clk)
    begin
        cyc++;
        step_hi += int'(step === 1'h1);
        if (cyc == 30000)
        begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
        host_u.xfer(c, d, n, 1'h0, v);
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
        host_u.xfer(c, 16'h0000, 2, 1'h1, v);
        `CHK(v & m, e)
    endtask
    initial
    begin
        w(2);
        rst = 1'h0;
        w(10);
        rc(CMD_OPERATION, 16'h00FF, 16'h0080);
        host_u.dev_addr = 7'h40;
        wr(CMD_OPERATION, 16'h0000, 1);
        `CHK({host_u.addr_nack, gate}, 2'h3)
        host_u.dev_addr = 7'h47;
        temp = 16'h007E;
        step_hi = 0;
        w(400);
        `CHK(step_hi, 80)
        rc(CMD_TEMP, 16'hFFFF, 16'h007E);
        `CHK({alert_oe_n, gate}, 2'h1)
        temp = 16'h0014;
        w(80);
        `CHK(alert_oe_n, 1'h0)
        wr(CMD_CLEAR_FLAGS, 16'h0000, 0);
        `CHK(alert_oe_n, 1'h1)
        temp = 16'h0097;
        w(80);
        rc(CMD_DIAG, 16'h0008, 16'h0008);
        temp = 16'h0014;
        w(80);
        `CHK(gate, 1'h0)
        wr(CMD_OPERATION, 16'h0000, 1);
        wr(CMD_OPERATION, 16'h0080, 1);
        `CHK(gate, 1'h1)
        wr(CMD_CLEAR_FLAGS, 16'h0000, 0);
        $display("test temperature done");
        wr(CMD_OT_WARN, 16'h0014, 2);
        temp = 16'h0015;
        w(80);
        rc(CMD_DIAG, 16'h0004, 16'h0004);
        ov = 1'h1;
        w(10);
        `CHK(gate, 1'h0)
        ov = 1'h0;
        rc(CMD_OT_WARN, 16'hFFFF, 16'h0014);
        wr(CMD_OPERATION, 16'h0000, 1);
        `CHK(gate, 1'h0)
        sense = 1'h1;
        rc(CMD_VSTATUS, 16'h0080, 16'h0080);
        rc(CMD_DIAG, 16'h0001, 16'h0001);
        wr(CMD_ALERT_MASK, 16'h003F, 2);
        wr(CMD_CLEAR_FLAGS, 16'h0000, 0);
        `CHK(alert_oe_n, 1'h1)
        sense = 1'h0;
        wr(CMD_OPERATION, 16'h0080, 1);
        $display("test pins done");
        lim_sel = 1'h0;
        brk_sel = 1'h1;
        cla = 1'h1;
        w(10);
        `CHK({cl50, cbhi, ftr, gate}, 4'hF)
        // one retry allowed: first timeout waits for the ramp, second locks out
        wr(CMD_SETUP, 16'h0011, 1);
        `CHK(cl50, 1'h0)
        texp = 1'h1;
        w(10);
        texp = 1'h0;
        `CHK(gate, 1'h0)
        ramp = 1'h1;
        w(10);
        ramp = 1'h0;
        `CHK(gate, 1'h1)
        texp = 1'h1;
        w(10);
        texp = 1'h0;
        `CHK(gate, 1'h0)
        rc(CMD_DIAG, 16'h0002, 16'h0002);
        en = 1'h0;
        w(10);
        `CHK(gate, 1'h0)
        en = 1'h1;
        w(10);
        `CHK(gate, 1'h1)
        ref_low = 1'h1;
        w(5);
        ref_low = 1'h0;
        w(10);
        rc(CMD_OT_WARN, 16'hFFFF, 16'h007D);
        `CHK(cl50, 1'h1)
        $display("test lockout done");
        test_done();
    end
endmodule // hotswap_protect_control_tb
